// ---- src/boot_cfg_pkg.sv ----
package boot_cfg_pkg;
  // ------------------------------------------------------------
  // option byte location and values
  // ------------------------------------------------------------
  localparam logic [15:0] OPT_ADDR_4K    = 16'h0fff;
  localparam logic [15:0] OPT_ADDR_2K    = 16'h07ff;
  localparam logic [15:0] OPT_ALIAS_ADDR = 16'hffff;
  localparam logic [7:0]  OPT_RESET      = 8'h00;
  localparam logic [7:0]  TRAP_OPCODE    = 8'h00;
  localparam logic [7:0]  PROTECT_RDATA  = 8'hff;
  // ------------------------------------------------------------
  // option byte field positions
  // ------------------------------------------------------------
  localparam int BIT_BOOT_FLASH = 0;
  localparam int BIT_HALT_DIS   = 1;
  localparam int BIT_WDOG_DIS   = 2;
  localparam int BIT_OSC_LO     = 3;
  localparam int BIT_OSC_MID    = 4;
  localparam int BIT_PROTECT    = 5;
  localparam int BIT_OSC_HI     = 6;
  localparam int BIT_RESERVED   = 7;
  // ------------------------------------------------------------
  // serial pin setup and shifter bit count for the loader
  // ------------------------------------------------------------
  localparam logic [1:0] SER_CFG_CLK_SO = 2'h1;
  localparam logic [2:0] BIT_CNT_LAST   = 3'h7;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_INT_RC   = 3'b000,
    OSC_EXT_R    = 3'b001,
    OSC_XTAL_FB  = 3'b010,
    OSC_XTAL_UFB = 3'b011,
    OSC_EXTERNAL = 3'b100
  } osc_mode_t;
  typedef enum logic [1:0] {
    SRC_USER    = 2'b00,
    SRC_BOOTROM = 2'b01,
    SRC_EMUL    = 2'b10
  } exec_src_t;
  typedef enum logic [1:0] {
    OP_READ       = 2'b00,
    OP_WRITE      = 2'b01,
    OP_PAGE_ERASE = 2'b10,
    OP_MASS_ERASE = 2'b11
  } flash_op_t;
  typedef enum logic {
    ST_CAPTURE = 1'b0,
    ST_RUN     = 1'b1
  } cfg_state_t;
endpackage : boot_cfg_pkg

// ---- src/boot_option_security_ctrl.sv ----
`timescale 1ns/100ps
module boot_option_security_ctrl
#(
  parameter bit IS_4K  = 1'b1,
  parameter int ADDR_W = 16,
  parameter int PAGE_W = 9
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // operating context
  input  wire boot_cfg_pkg::exec_src_t exec_src,
  input  wire logic                  opt_prog_en,
  input  wire logic                  loader_active,
  // instruction fetch
  input  wire logic                  fetch_req,
  input  wire logic [ADDR_W-1:0]     fetch_addr,
  input  wire logic [7:0]            fetch_rdata,
  output logic                       instr_valid,
  output logic [7:0]                 instr_data,
  output logic                       trap_req,
  // flash access from core or loader
  input  wire logic                  acc_req,
  input  wire boot_cfg_pkg::flash_op_t acc_op,
  input  wire logic [ADDR_W-1:0]     acc_addr,
  input  wire logic [7:0]            acc_wdata,
  input  wire logic [7:0]            flash_rdata,
  output logic                       acc_done,
  output logic                       acc_blocked,
  output logic [7:0]                 acc_rdata,
  // flash array command
  output logic                       flash_req,
  output boot_cfg_pkg::flash_op_t    flash_op,
  output logic [ADDR_W-1:0]          flash_addr,
  output logic [7:0]                 flash_wdata,
  // configuration latches
  output logic                       cfg_ready,
  output logic                       boot_from_flash,
  output logic                       read_protect,
  output boot_cfg_pkg::osc_mode_t    osc_mode,
  output logic                       wdog_enable,
  output logic                       wdog_pin_is_wdog,
  output logic                       wdog_pin_pullup,
  output logic                       halt_enable,
  // serial port setup
  output logic                       serial_port_select,
  output logic [1:0]                 port_config,
  output logic                       clock_pin_pullup,
  output logic                       serial_in_alt,
  // serial byte exchange with core
  input  wire logic                  tx_load,
  input  wire logic [7:0]            tx_byte,
  output logic                       rx_valid,
  output logic [7:0]                 rx_data,
  // serial link pins
  input  wire logic                  serial_shift_clock,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       serial_out_oe_n
);
  import boot_cfg_pkg::*;
  if (ADDR_W != 16 || PAGE_W < 1 || PAGE_W > 11) begin : g_chk
    $error("boot_option_security_ctrl: unsupported ADDR_W or PAGE_W");
  end
  // ------------------------------------------------------------
  // option storage and access decode
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OPT_ADDR = IS_4K ? OPT_ADDR_4K : OPT_ADDR_2K;
  logic [7:0]      opt_reg = OPT_RESET;
  logic [7:0]      opt_next, cfg_reg, cfg_next;
  cfg_state_t      state_reg, state_next;
  logic            hit_opt, hit_alias, hit_page, untrusted, blocked;
  logic            done_next, blk_next, freq_next, ivalid_next, trap_next;
  logic [7:0]      rdata_next, idata_next;
  logic [7:0]      txd_reg, txd_next, rxd_next;
  logic            rxv_next;
  logic [2:0]      rxs_reg, rxs_next;
  assign hit_opt   = acc_addr == OPT_ADDR;
  assign hit_alias = IS_4K && acc_addr == OPT_ALIAS_ADDR;
  assign hit_page  = acc_addr[ADDR_W-1:PAGE_W] == OPT_ADDR[ADDR_W-1:PAGE_W];
  // the user loader enforces its own policy, so only these sources are fenced
  assign untrusted = exec_src != SRC_USER;
  assign blocked   = cfg_reg[BIT_PROTECT] && untrusted && acc_op != OP_MASS_ERASE
                     && !(acc_op == OP_READ && hit_alias);
  always_comb begin
    opt_next    = opt_reg;
    cfg_next    = cfg_reg;
    state_next  = state_reg;
    done_next   = 1'b0;
    blk_next    = 1'b0;
    freq_next   = 1'b0;
    rdata_next  = acc_rdata;
    ivalid_next = 1'b0;
    trap_next   = 1'b0;
    idata_next  = instr_data;
    case (state_reg)
      ST_CAPTURE: begin
        // settings freeze before the first fetch is served
        cfg_next   = opt_reg;
        state_next = ST_RUN;
      end
      ST_RUN: begin
        if (fetch_req) begin
          ivalid_next = 1'b1;
          if (fetch_addr == OPT_ADDR) begin
            idata_next = TRAP_OPCODE;
            trap_next  = 1'b1;
          end else begin
            idata_next = fetch_rdata;
          end
        end
        if (acc_req) begin
          done_next = 1'b1;
          blk_next  = blocked;
          if (blocked) begin
            rdata_next = PROTECT_RDATA;
          end else begin
            case (acc_op)
              OP_READ: begin
                rdata_next = (hit_opt || hit_alias) ? opt_reg : flash_rdata;
              end
              OP_WRITE: begin
                if (hit_opt && !opt_prog_en) begin
                  blk_next = 1'b1;
                end else begin
                  freq_next = 1'b1;
                  if (hit_opt) begin
                    opt_next = acc_wdata;
                  end
                end
              end
              OP_PAGE_ERASE: begin
                freq_next = 1'b1;
                if (hit_page && opt_prog_en) begin
                  opt_next = OPT_RESET;
                end
              end
              OP_MASS_ERASE: begin
                freq_next = 1'b1;
                opt_next  = OPT_RESET;
              end
              default: begin
                blk_next = 1'b1;
              end
            endcase
          end
        end
      end
      default: begin
        state_next = ST_CAPTURE;
      end
    endcase
  end
  // option storage rides through rst so a programmed byte survives it
  always_ff @(posedge ref_clk) opt_reg <= opt_next;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_reg     <= OPT_RESET;
      state_reg   <= ST_CAPTURE;
      acc_done    <= 1'b0;
      acc_blocked <= 1'b0;
      acc_rdata   <= 8'h00;
      flash_req   <= 1'b0;
      flash_op    <= OP_READ;
      flash_addr  <= '0;
      flash_wdata <= 8'h00;
      instr_valid <= 1'b0;
      instr_data  <= 8'h00;
      trap_req    <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      state_reg   <= state_next;
      acc_done    <= done_next;
      acc_blocked <= blk_next;
      acc_rdata   <= rdata_next;
      flash_req   <= freq_next;
      flash_op    <= acc_op;
      flash_addr  <= acc_addr;
      flash_wdata <= acc_wdata;
      instr_valid <= ivalid_next;
      instr_data  <= idata_next;
      trap_req    <= trap_next;
    end
  end
  // ------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------
  assign cfg_ready        = state_reg == ST_RUN;
  assign boot_from_flash  = cfg_reg[BIT_BOOT_FLASH];
  assign read_protect     = cfg_reg[BIT_PROTECT];
  assign osc_mode         = cfg_reg[BIT_OSC_HI] ? OSC_EXTERNAL :
                            osc_mode_t'({1'b0, cfg_reg[BIT_OSC_MID], cfg_reg[BIT_OSC_LO]});
  assign wdog_enable      = !cfg_reg[BIT_WDOG_DIS];
  assign wdog_pin_is_wdog = !cfg_reg[BIT_WDOG_DIS];
  assign wdog_pin_pullup  = !cfg_reg[BIT_WDOG_DIS];
  assign halt_enable      = !cfg_reg[BIT_HALT_DIS];
  // ------------------------------------------------------------
  // serial port setup for the loader
  // ------------------------------------------------------------
  assign serial_port_select = loader_active;
  assign port_config        = loader_active ? SER_CFG_CLK_SO : 2'h0;
  assign clock_pin_pullup   = loader_active;
  assign serial_in_alt      = loader_active;
  assign serial_out_oe_n    = !loader_active;
  // ------------------------------------------------------------
  // link domain: slave shifter on the master's clock
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg, rx_byte_reg, tx_sh_reg;
  logic       rx_tgl_reg, so_reg;
  // no free-running edges assumed; every step rides a master edge
  always_ff @(posedge serial_shift_clock or posedge rst) begin
    if (rst) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg   <= 8'h00;
      rx_byte_reg <= 8'h00;
      rx_tgl_reg  <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_sh_reg   <= {rx_sh_reg[6:0], serial_in};
      if (bit_cnt_reg == BIT_CNT_LAST) begin
        rx_byte_reg <= {rx_sh_reg[6:0], serial_in};
        rx_tgl_reg  <= !rx_tgl_reg;
      end
    end
  end
  // tx byte is held still by the core between load and the byte's end
  always_ff @(negedge serial_shift_clock or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= 8'h00;
      so_reg    <= 1'b1;
    end else if (bit_cnt_reg == 3'h0) begin
      so_reg    <= txd_reg[7];
      tx_sh_reg <= {txd_reg[6:0], 1'b0};
    end else begin
      so_reg    <= tx_sh_reg[7];
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end
  assign serial_out = so_reg;
  // ------------------------------------------------------------
  // core side of the byte exchange
  // ------------------------------------------------------------
  always_comb begin
    txd_next = tx_load ? tx_byte : txd_reg;
    rxs_next = {rxs_reg[1:0], rx_tgl_reg};
    rxv_next = rxs_reg[2] != rxs_reg[1];
    rxd_next = rxv_next ? rx_byte_reg : rx_data;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txd_reg  <= 8'h00;
      rxs_reg  <= 3'h0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      txd_reg  <= txd_next;
      rxs_reg  <= rxs_next;
      rx_valid <= rxv_next;
      rx_data  <= rxd_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_fetch_opt;
    fetch_req && cfg_ready && fetch_addr == OPT_ADDR;
  endsequence
  sequence s_prot_read;
    acc_req && cfg_ready && acc_op == OP_READ && read_protect && untrusted && !hit_alias;
  endsequence
  property p_boot_src;
    cfg_ready && $past(cfg_ready) |-> $stable(boot_from_flash) && $stable(cfg_reg);
  endproperty
  a_boot_src: assert property (p_boot_src) else $error("boot source moved");
  property p_trap;
    s_fetch_opt |=> instr_valid && instr_data == 8'h00 && trap_req;
  endproperty
  a_trap: assert property (p_trap) else $error("option fetch not trapped");
  property p_opt_guard;
    acc_req && acc_op == OP_WRITE && hit_opt && !opt_prog_en |=> $stable(opt_reg);
  endproperty
  a_opt_guard: assert property (p_opt_guard) else $error("option written");
  property p_prot_ff;
    s_prot_read |=> acc_done && acc_blocked && acc_rdata == 8'hff;
  endproperty
  a_prot_ff: assert property (p_prot_ff) else $error("protected read leaked");
  property p_prot_nowr;
    acc_req && cfg_ready && acc_op != OP_MASS_ERASE && acc_op != OP_READ
      && read_protect && untrusted |=> !flash_req;
  endproperty
  a_prot_nowr: assert property (p_prot_nowr) else $error("protected write issued");
  property p_mass;
    acc_req && cfg_ready && acc_op == OP_MASS_ERASE |=> flash_req && opt_reg == 8'h00;
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase refused");
  property p_alias;
    acc_req && cfg_ready && acc_op == OP_READ && hit_alias |=> acc_rdata == $past(opt_reg);
  endproperty
  a_alias: assert property (p_alias) else $error("alias read wrong");
  property p_user;
    acc_req && cfg_ready && exec_src == SRC_USER && !(acc_op == OP_WRITE && hit_opt)
      |=> !acc_blocked ##0 (flash_req || flash_op == OP_READ);
  endproperty
  a_user: assert property (p_user) else $error("user access blocked");
  property p_capture;
    $rose(cfg_ready) |-> cfg_reg == $past(opt_reg) ##1 cfg_ready [*2];
  endproperty
  a_capture: assert property (p_capture) else $error("option not latched");
  property p_ser_pins;
    loader_active |-> port_config == 2'h1 && !serial_out_oe_n && clock_pin_pullup;
  endproperty
  a_ser_pins: assert property (p_ser_pins) else $error("serial pins wrong");
endmodule : boot_option_security_ctrl

// ---- verification/boot_option_security_ctrl_tb.sv ----
`timescale 1ns/100ps
module boot_option_security_ctrl_tb;
  import boot_cfg_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        ref_clk, rst, opt_prog_en, loader_active, fetch_req, acc_req, tx_load;
  exec_src_t   exec_src;
  flash_op_t   acc_op, flash_op;
  osc_mode_t   osc_mode;
  logic [15:0] fetch_addr, acc_addr, flash_addr, ra;
  logic [7:0]  fetch_rdata, acc_wdata, flash_rdata, instr_data, acc_rdata, flash_wdata;
  logic [7:0]  tx_byte, rx_data, host_tx, host_rx, v, r;
  logic        instr_valid, trap_req, acc_done, acc_blocked, flash_req, cfg_ready;
  logic        boot_from_flash, read_protect, wdog_enable, wdog_pin_is_wdog, wdog_pin_pullup;
  logic        halt_enable, serial_port_select, clock_pin_pullup, serial_in_alt, rx_valid;
  logic [1:0]  port_config;
  logic [2:0]  osc;
  logic [8:0]  cfg_vec;
  logic        serial_shift_clock, serial_in, serial_out, serial_out_oe_n;
  logic        host_go, host_slow, host_busy;
  int          err_count, cmp_count;
  assign cfg_vec = {boot_from_flash, read_protect, osc_mode, wdog_enable, wdog_pin_is_wdog,
                    wdog_pin_pullup, halt_enable};
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  boot_option_security_ctrl u_boot_option_security_ctrl (
    .ref_clk(ref_clk), .rst(rst), .exec_src(exec_src), .opt_prog_en(opt_prog_en),
    .loader_active(loader_active), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_rdata(fetch_rdata), .instr_valid(instr_valid), .instr_data(instr_data),
    .trap_req(trap_req), .acc_req(acc_req), .acc_op(acc_op), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .flash_rdata(flash_rdata), .acc_done(acc_done),
    .acc_blocked(acc_blocked), .acc_rdata(acc_rdata), .flash_req(flash_req),
    .flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .cfg_ready(cfg_ready), .boot_from_flash(boot_from_flash), .read_protect(read_protect),
    .osc_mode(osc_mode), .wdog_enable(wdog_enable), .wdog_pin_is_wdog(wdog_pin_is_wdog),
    .wdog_pin_pullup(wdog_pin_pullup), .halt_enable(halt_enable),
    .serial_port_select(serial_port_select), .port_config(port_config),
    .clock_pin_pullup(clock_pin_pullup), .serial_in_alt(serial_in_alt), .tx_load(tx_load),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_data(rx_data),
    .serial_shift_clock(serial_shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  serial_host_model u_serial_host_model (
    .go(host_go), .slow(host_slow), .tx_byte(host_tx), .busy(host_busy), .rx_byte(host_rx),
    .serial_shift_clock(serial_shift_clock), .serial_in(serial_in),
    .serial_out(serial_out));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;
  function automatic logic [8:0] exp_cfg(input logic [7:0] o);
    return {o[0], o[5], (o[6] ? 3'b100 : {1'b0, o[4], o[3]}), ~o[2], ~o[2], ~o[2], ~o[1]};
  endfunction : exp_cfg
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic do_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(cfg_ready), 16'h1);
  endtask : do_reset
  // fr: also check that the array command follows the verdict
  task automatic acc(input flash_op_t op, input logic [15:0] a, input logic [7:0] wd,
                     input logic [7:0] frd, input logic blk, input logic [7:0] erd,
                     input logic fr);
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_op <= op;
    acc_addr <= a;
    acc_wdata <= wd;
    flash_rdata <= frd;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    #1;
    chk(16'(acc_done), 16'h1);
    chk(16'(acc_blocked), 16'(blk));
    if (op == OP_READ) begin
      chk(16'(acc_rdata), 16'(erd));
    end else if (fr) begin
      chk(16'(flash_req), 16'(!blk));
    end
    if (fr && !blk) begin
      chk(16'(flash_op), 16'(op));
      chk(flash_addr, a);
      chk(16'(flash_wdata), 16'(wd));
    end
  endtask : acc
  task automatic fetch(input logic [15:0] a, input logic [7:0] d, input logic t);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    fetch_rdata <= d;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    #1;
    chk(16'(instr_valid), 16'h1);
    chk(16'(instr_data), t ? 16'(TRAP_OPCODE) : 16'(d));
    chk(16'(trap_req), 16'(t));
  endtask : fetch
  task automatic xfer(input logic [7:0] t, input logic [7:0] h, input logic s);
    int n;
    @(posedge ref_clk);
    tx_load <= 1'b1;
    tx_byte <= t;
    host_tx <= h;
    host_slow <= s;
    @(posedge ref_clk);
    tx_load <= 1'b0;
    host_go <= ~host_go;
    n = 0;
    while (rx_valid !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(16'(n < 200), 16'h1);
    chk(16'(rx_data), 16'(h));
    wait (host_busy === 1'b0);
    chk(16'(host_rx), 16'(t));
  endtask : xfer
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  initial begin
    {ref_clk, rst, opt_prog_en, loader_active, fetch_req, acc_req, tx_load} = 7'h20;
    {host_go, host_slow} = 2'h0;
    exec_src = SRC_USER;
    acc_op = OP_READ;
    {fetch_addr, acc_addr, fetch_rdata, acc_wdata, flash_rdata, tx_byte, host_tx} = '0;
    err_count = 0;
    cmp_count = 0;
    r = 8'($urandom(53));
    do_reset();
    chk(16'(cfg_vec), 16'(exp_cfg(OPT_RESET)));
    acc(OP_READ, OPT_ADDR_4K, 8'h00, 8'h5c, 1'b0, OPT_RESET, 1'b0);
    fetch(OPT_ADDR_4K, 8'h3c, 1'b1);
    repeat (3) fetch(16'h0100 + 16'($urandom_range(0, 16'h0dff)), 8'($urandom), 1'b0);
    acc(OP_WRITE, OPT_ADDR_4K, 8'h41, 8'h00, 1'b1, 8'h00, 1'b0);
    acc(OP_READ, OPT_ADDR_4K, 8'h00, 8'h77, 1'b0, OPT_RESET, 1'b0);
    for (int k = 0; k < 6; k++) begin
      osc = (k == 5) ? 3'h7 : 3'(k);
      v = {1'b0, osc[2], (k == 4 || k == 5) | 1'($urandom), osc[1:0], 3'($urandom)};
      if (k == 4) v[0] = 1'b1;
      exec_src <= SRC_USER;
      opt_prog_en <= 1'b1;
      // erase before program, reserved bit kept low by the programmer
      acc(OP_MASS_ERASE, 16'h0000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
      acc(OP_WRITE, OPT_ADDR_4K, v, 8'h00, 1'b0, 8'h00, 1'b0);
      opt_prog_en <= 1'b0;
      do_reset();
      chk(16'(cfg_vec), 16'(exp_cfg(v)));
      acc(OP_READ, OPT_ADDR_4K, 8'h00, ~v, 1'b0, v, 1'b0);
      if (v[5]) begin
        for (int s = 1; s < 3; s++) begin
          exec_src <= exec_src_t'(s);
          ra = 16'h0100 + 16'($urandom_range(0, 16'h0dff));
          r = 8'($urandom);
          acc(OP_READ, ra, 8'h00, r, 1'b1, PROTECT_RDATA, 1'b0);
          acc(OP_WRITE, ra, r, 8'h00, 1'b1, 8'h00, 1'b1);
          acc(OP_PAGE_ERASE, ra, 8'h00, 8'h00, 1'b1, 8'h00, 1'b1);
          acc(OP_READ, OPT_ALIAS_ADDR, 8'h00, ~v, 1'b0, v, 1'b0);
        end
        exec_src <= SRC_USER;
        acc(OP_READ, ra, 8'h00, r, 1'b0, r, 1'b0);
        acc(OP_WRITE, ra, r, 8'h00, 1'b0, 8'h00, 1'b1);
        acc(OP_PAGE_ERASE, ra, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
        exec_src <= SRC_BOOTROM;
        acc(OP_MASS_ERASE, 16'h0000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
        exec_src <= SRC_USER;
        acc(OP_READ, OPT_ADDR_4K, 8'h00, 8'h99, 1'b0, OPT_RESET, 1'b0);
      end
    end
    @(posedge ref_clk);
    loader_active <= 1'b1;
    #1;
    chk(16'(port_config), 16'(SER_CFG_CLK_SO));
    chk(16'({serial_port_select, clock_pin_pullup, serial_in_alt, serial_out_oe_n}),
        16'h000e);
    chk(16'(serial_shift_clock), 16'h1);
    for (int i = 0; i < 5; i++) begin
      xfer((i == 0) ? 8'h80 : 8'($urandom), (i == 1) ? 8'h01 : 8'($urandom), 1'(i));
    end
    @(posedge ref_clk);
    loader_active <= 1'b0;
    #1;
    chk(16'(serial_out_oe_n), 16'h1);
    report_and_stop();
  end
endmodule : boot_option_security_ctrl_tb

// ---- verification/serial_host_model.sv ----
`timescale 1ns/100ps
module serial_host_model (
  // bench control
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  output logic            busy,
  output logic [7:0]      rx_byte,
  // link pins
  output logic            serial_shift_clock,
  output logic            serial_in,
  input  wire logic       serial_out
);
  initial begin
    serial_shift_clock = 1'b1;
    serial_in = 1'b0;
    busy = 1'b0;
    rx_byte = 8'h00;
    // swallow the bench's first settle of go at time zero
    wait (go === 1'b0);
    forever begin
      @(go);
      busy = 1'b1;
      // offset keeps the link clock out of phase with ref_clk
      #1.3;
      for (int i = 7; i >= 0; i--) begin
        serial_shift_clock = 1'b0;
        serial_in = tx_byte[i];
        #7.5;
        serial_shift_clock = 1'b1;
        rx_byte[i] = serial_out;
        #7.5;
        // slow host parks the clock high mid byte
        if (slow && i == 4) begin
          #60;
        end
      end
      // released data line must not keep looking valid
      serial_in = ~serial_in;
      busy = 1'b0;
    end
  end
endmodule : serial_host_model
